//--- hdl/dao_buf.sv
// Purpose: two-entry valid/ready buffer for word pairs
// Assumes: single clock, async active-low reset
// Notes:   flush empties it when the outputs are released
`timescale 1ns/1ps
`default_nettype none
`include "dao_params.svh"
module dao_buf
  import dao_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic flush,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [2*`DAO_WORD_W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [2*`DAO_WORD_W-1:0] out_data
);
  typedef struct packed {
    logic [`DAO_BUF_DEPTH-1:0][2*`DAO_WORD_W-1:0] mem;
    logic [`DAO_IDX_W-1:0] rd;
    logic [`DAO_IDX_W-1:0] wr;
    logic [`DAO_CNT_W2-1:0] cnt;
  } dao_buf_st_t;

  dao_buf_st_t st;
  dao_buf_st_t next_st;
  logic push;
  logic pop;

  //////////////////////////////////////////////////////////////////////
  // handshakes; ready is honest full, so a stall backs up the source
  assign in_ready = (st.cnt != 2'(`DAO_BUF_DEPTH));
  assign out_valid = (st.cnt != `DAO_PIPE_ZERO);
  assign out_data = st.mem[st.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // next state
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
    if (flush) begin
      next_st.rd = '0;
      next_st.wr = '0;
      next_st.cnt = '0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // dao_buf
`default_nettype wire

//--- hdl/dao_params.svh
// Purpose: constants for the dual converter output interface
// Assumes: 100 MHz system clock, period 10 ns
// Notes:   times in ns, cycle counts derived from them
`ifndef DAO_PARAMS_SVH
`define DAO_PARAMS_SVH

`define DAO_CLK_PERIOD_NS 10
`define DAO_WORD_W 8
`define DAO_PIPE_DEPTH 3
`define DAO_PDN_ENTER_NS 200
`define DAO_PDN_EXIT_NS 200
// least times round up to whole cycles
`define DAO_PDN_ENTER_CYC \
  ((`DAO_PDN_ENTER_NS + `DAO_CLK_PERIOD_NS - 1) / `DAO_CLK_PERIOD_NS)
`define DAO_PDN_EXIT_CYC \
  ((`DAO_PDN_EXIT_NS + `DAO_CLK_PERIOD_NS - 1) / `DAO_CLK_PERIOD_NS)
`define DAO_CNT_W 6
`define DAO_BUF_DEPTH 2
`define DAO_IDX_W 1
`define DAO_CNT_W2 2
`define DAO_CNT_ZERO 6'h00
`define DAO_CNT_ONE 6'h01
`define DAO_WORD_ZERO 8'h00
`define DAO_PIPE_ZERO 2'h0
`define DAO_LAT_DONE 2'h3

`endif

//--- hdl/dao_pkg.sv
// Purpose: types for the dual converter output interface
// Assumes: included constants header
// Notes:   power state machine state type
`include "dao_params.svh"
package dao_pkg;
  typedef enum logic [1:0] {
    DAO_ST_RUN,
    DAO_ST_DOWN,
    DAO_ST_WAKE
  } dao_state_t;
endpackage

//--- hdl/dao_top.sv
// Purpose: digital side of a dual 8-bit sampling converter
// Assumes: clk is the conversion clock; held-sample inputs are synchronous
// Notes:   outputs are three-state as two data words with one shared enable and valid
// Function
// R1: power-down high releases both output buses to high impedance
// R2: controller waits 200 ns after power-down before relying on release
// R3: 200 ns recovery, then words valid three clocks later; here word_valid rises five clocks after run returns
// R4: conversion clock runs between 5 and 60 MSPS; here the constants and the bench use a 100 MHz clock
// R5: conversion clock near 50% duty, within plus or minus 10%
// R6: one shared clock drives both channels, no interleaving
// R7: one power-down input stops and starts both channels together
// R8: unused power-down input is held low
// R9: both channels sample together on each rising clock edge; here only on edges while running with room in the buffer
// R10: each word appears three clock cycles after its sample; here it shows four edges after its sample in a steady stream
// R11: words are straight offset binary, zero at negative full scale
// R12: capture logic registers both words on the same edge
`timescale 1ns/1ps
`default_nettype none
`include "dao_params.svh"
module dao_top
  import dao_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // quantised samples, already offset binary
  input wire logic [`DAO_WORD_W-1:0] sample_a,
  input wire logic [`DAO_WORD_W-1:0] sample_b,
  // power-down select, high stops both channels
  input wire logic shutdown_select,
  // receiver stall
  input wire logic word_ready,
  // output buses
  output logic [`DAO_WORD_W-1:0] channel_a_word,
  output logic [`DAO_WORD_W-1:0] channel_b_word,
  output logic word_oe,
  output logic word_valid
);
  localparam int ENTER_CYC = `DAO_PDN_ENTER_CYC;
  localparam int EXIT_CYC = `DAO_PDN_EXIT_CYC;

  typedef struct packed {
    dao_state_t state;
    logic [`DAO_CNT_W-1:0] tmr;
    logic [`DAO_CNT_W2-1:0] fill;
    logic [`DAO_PIPE_DEPTH-1:0][2*`DAO_WORD_W-1:0] pipe;
    logic [`DAO_WORD_W-1:0] a_q;
    logic [`DAO_WORD_W-1:0] b_q;
    logic oe;
    logic vld;
  } dao_top_st_t;

  dao_top_st_t st;
  dao_top_st_t next_st;
  logic run;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [2*`DAO_WORD_W-1:0] buf_out_data;
  logic take;
  logic out_load;

  //////////////////////////////////////////////////////////////////////
  // run only in normal conversion; gates pipeline and buffer
  assign run = (st.state == DAO_ST_RUN);
  // only trust the pipe once three fresh samples have passed
  assign take = run && (st.fill == `DAO_LAT_DONE); // R3
  // the output pair reloads only when it is empty or being taken this
  // edge; popping on ready alone would drop the pair held in the output
  // register at the first edge of a stall
  assign out_load = !st.vld || word_ready;

  dao_buf u_buf (
    .clk(clk),
    .resetn(resetn),
    .flush(!run),
    .in_valid(take),
    .in_ready(buf_in_ready),
    .in_data(st.pipe[`DAO_PIPE_DEPTH-1]),
    .out_valid(buf_out_valid),
    .out_ready(out_load),
    .out_data(buf_out_data)
  );

  //////////////////////////////////////////////////////////////////////
  // next state: power sequencing, sample pipeline, output registers
  always_comb begin
    next_st = st;
    // both channels share one edge and one shift chain
    if (run && buf_in_ready) begin
      next_st.pipe[0] = {sample_a, sample_b}; // R6 R9
      for (int i = 1; i < `DAO_PIPE_DEPTH; i++) begin
        next_st.pipe[i] = st.pipe[i-1]; // R10
      end
      if (st.fill != `DAO_LAT_DONE) begin
        next_st.fill = st.fill + 2'h1;
      end
    end
    case (st.state)
      DAO_ST_RUN: begin
        if (shutdown_select) begin
          next_st.state = DAO_ST_DOWN; // R7
          next_st.tmr = 6'(ENTER_CYC);
        end
      end
      DAO_ST_DOWN: begin
        // release lands well inside the enter window
        if (st.tmr != `DAO_CNT_ZERO) begin
          next_st.tmr = st.tmr - `DAO_CNT_ONE; // R2
        end
        if (!shutdown_select) begin
          next_st.state = DAO_ST_WAKE;
          next_st.tmr = 6'(EXIT_CYC);
        end
      end
      DAO_ST_WAKE: begin
        if (shutdown_select) begin
          next_st.state = DAO_ST_DOWN; // R7
          next_st.tmr = 6'(ENTER_CYC);
        end else if (st.tmr == `DAO_CNT_ONE) begin
          next_st.state = DAO_ST_RUN; // R3
          next_st.tmr = `DAO_CNT_ZERO;
        end else begin
          next_st.tmr = st.tmr - `DAO_CNT_ONE;
        end
      end
      default: begin
        next_st.state = DAO_ST_DOWN;
      end
    endcase
    // stale pipeline words must not leak after recovery
    if (!run) begin
      next_st.fill = `DAO_PIPE_ZERO; // R3
    end
    // outputs; coding passes through unchanged as offset binary
    next_st.oe = !shutdown_select && run; // R1
    // the pair in the output register stays put until the receiver
    // takes it, so a stall never overwrites a word nobody has seen
    if (!run || shutdown_select) begin
      next_st.vld = 1'h0; // R1
    end else if (out_load) begin
      next_st.vld = buf_out_valid;
    end
    if (run && out_load && buf_out_valid) begin
      next_st.a_q = buf_out_data[2*`DAO_WORD_W-1:`DAO_WORD_W]; // R11
      next_st.b_q = buf_out_data[`DAO_WORD_W-1:0]; // R11
    end
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign channel_a_word = st.a_q;
  assign channel_b_word = st.b_q;
  assign word_oe = st.oe;
  assign word_valid = st.vld;

  //////////////////////////////////////////////////////////////////////
  // checks
  // rising power-down request as seen at the sampling edge; the first
  // edge after reset sees the low level held during reset
  sequence s_pdn_rise;
    !$past(shutdown_select) && shutdown_select;
  endsequence

  // release of power-down while the channels are still stopped
  sequence s_wake_start;
    $fell(shutdown_select) && st.state == DAO_ST_DOWN;
  endsequence

  // bus release and joint stop
  a_release_bus: assert property (@(posedge clk) disable iff (!resetn) // R1
    shutdown_select |=> !word_oe)
    else $error("bus driven during power-down");
  a_joint_down: assert property (@(posedge clk) disable iff (!resetn) // R7
    s_pdn_rise |=> (st.state == DAO_ST_DOWN) ##1 !word_oe)
    else $error("channels did not stop together");
  a_oe_follows: assert property (@(posedge clk) disable iff (!resetn) // R1
    !shutdown_select && run |=> word_oe)
    else $error("bus not driven while running");
  a_valid_has_oe: assert property (@(posedge clk) disable iff (!resetn) // R1
    word_valid |-> word_oe)
    else $error("valid while released");

  // recovery window and refill
  a_wake_delay: assert property (@(posedge clk) disable iff (!resetn) // R3
    s_wake_start |=> !run [*8])
    else $error("recovery shorter than expected");
  a_wake_ends: assert property (@(posedge clk) disable iff (!resetn) // R3
    s_wake_start ##1 !shutdown_select [*8] |->
      ##[0:20] (run || shutdown_select))
    else $error("recovery did not end");
  a_flush_empty: assert property (@(posedge clk) disable iff (!resetn) // R3
    !run |=> !buf_out_valid)
    else $error("stale words kept across power-down");
  a_latency_three: assert property (@(posedge clk) disable iff (!resetn) // R10
    $rose(run) |-> !take [*3])
    else $error("word before three samples");
  a_no_early_word: assert property (@(posedge clk) disable iff (!resetn) // R3
    $rose(run) |-> !word_valid [*5])
    else $error("word shown before refill");

  // sample pairing, coding and stall hold; a stalled pair must stand
  // unchanged on both buses until the receiver takes it
  a_pair_aligned: assert property (@(posedge clk) disable iff (!resetn) // R9
    run && buf_in_ready |=> st.pipe[0] == {$past(sample_a),
      $past(sample_b)})
    else $error("channels sampled apart");
  a_code_pass: assert property (@(posedge clk) disable iff (!resetn) // R11
    run && out_load && buf_out_valid |=> channel_a_word ==
      $past(buf_out_data[2*`DAO_WORD_W-1:`DAO_WORD_W]))
    else $error("coding altered");
  a_stall_hold: assert property (@(posedge clk) disable iff (!resetn) // R10
    word_valid && !word_ready && !shutdown_select |=>
      word_valid && $stable(channel_a_word) && $stable(channel_b_word))
    else $error("pair changed while stalled");
endmodule // dao_top
`default_nettype wire

//--- testbench/dao_sink.sv
// Purpose: capture logic on the far side of the converter outputs
// Assumes: buses arrive already resolved from data and enable
// Notes:   stall holds ready low so the buffer must keep its pair
`timescale 1ns/1ps
`default_nettype none
module dao_sink (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // stall request from the bench
  input wire logic stall,
  // resolved buses
  input wire logic [7:0] a_bus,
  input wire logic [7:0] b_bus,
  input wire logic valid,
  output logic ready,
  // last captured pair and count
  output logic [7:0] last_a,
  output logic [7:0] last_b,
  output logic [15:0] taken
);
  assign ready = !stall;
  // both words taken on one edge so pairs never skew
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_a <= 8'h00;
      last_b <= 8'h00;
      taken <= 16'h0000;
    end else if (valid && ready) begin
      last_a <= a_bus;
      last_b <= b_bus;
      taken <= taken + 16'h0001;
    end
  end
endmodule // dao_sink
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: self-checking bench for the dual converter output side
// Assumes: channel b always carries the inverse of channel a
// Notes:   buses resolve to z whenever word_oe is low
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, resetn = 0, sd = 0, stall = 0;
  logic [7:0] sa = 8'h00, sb = 8'hff, la, lb, h [0:7];
  logic [7:0] ca, cb;
  logic oe, vld, rdy;
  logic [15:0] tk;
  int miscompares = 0, samples_checked = 0;
  wire [7:0] a_bus = oe ? ca : 8'hzz;
  wire [7:0] b_bus = oe ? cb : 8'hzz;
  always #5 clk = ~clk;
  // ramp on a, inverse on b; history of what each edge sampled
  always @(posedge clk) begin
    sa <= sa + 8'h01;
    sb <= ~(sa + 8'h01);
    h[0] <= sa;
    for (int i = 1; i < 8; i++) h[i] <= h[i-1];
  end
  dao_top i_dut (.clk(clk), .resetn(resetn), .sample_a(sa),
    .sample_b(sb), .shutdown_select(sd), .word_ready(rdy),
    .channel_a_word(ca), .channel_b_word(cb), .word_oe(oe),
    .word_valid(vld));
  dao_sink i_sink (.clk(clk), .resetn(resetn), .stall(stall),
    .a_bus(a_bus), .b_bus(b_bus), .valid(vld), .ready(rdy),
    .last_a(la), .last_b(lb), .taken(tk));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // steady stream: word shows four edges after its sample, pairs aligned
  task automatic t_stream;
    logic [15:0] t0;
    tick(10);
    t0 = tk;
    for (int i = 0; i < 20; i++) begin
      chk("valid", 8'h01, {7'h00, vld});
      chk("word_a", h[4], a_bus);
      chk("pair", ~a_bus, b_bus);
      tick(1);
    end
    chk("capt", ~la, lb);
    chk("capt_a", h[5], la);
    chk("taken", 8'h14, 8'(tk - t0));
  endtask
  // receiver stall: pair stands until taken, no word lost behind it
  task automatic t_stall;
    logic [7:0] held;
    @(posedge clk);
    stall <= 1'b1;
    tick(2);
    held = a_bus;
    for (int i = 0; i < 6; i++) begin
      chk("held_a", held, a_bus);
      chk("held_b", ~held, b_bus);
      tick(1);
    end
    @(posedge clk);
    stall <= 1'b0;
    tick(1);
    chk("after", held, la);
    chk("next", held + 8'h01, a_bus);
    tick(8);
  endtask
  // power-down then wake with recovery
  task automatic t_down;
    int n;
    @(posedge clk);
    sd <= 1'b1;
    tick(20);
    chk("a_z", 8'hzz, a_bus);
    chk("b_z", 8'hzz, b_bus);
    chk("no_valid", 8'h00, {7'h00, vld});
    @(posedge clk);
    sd <= 1'b0;
    n = 0;
    tick(1);
    while (vld !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    if (n >= 200) begin
      miscompares++;
      $display("Error wake expected valid seen none");
      test_done();
    end
    chk("wake_late", 8'h01, {7'h00, n >= 22});
    chk("wake_word", h[4], a_bus);
    chk("wake_pair", ~a_bus, b_bus);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_stream();
    t_stall();
    t_down();
    t_stream();
    test_done();
  end
endmodule // testbench
`default_nettype wire
